// file: cxv_core.v
// Exception entry sequencer with relocatable vector table
`timescale 1ns/1ps
`default_nettype none
`include "cxv_consts.vh"
// Contract
// RULE1: Table of 256 long words at base
// RULE2: Low 64 processor, upper 192 user vectors
// RULE3: Reset entry is SP then PC
// RULE4: Fetch address is base plus vector times four
// RULE5: Vector numbers are eight bits
// RULE6: Reset reads program space, others data space
// RULE7: Fixed vector numbers for internal exceptions
// RULE8: Spurious 24, autovectors 25 to 31; code never uses 24, a fault in acknowledge becomes a bus error
// RULE9: Trap index maps to 32 to 47
// RULE10: Copy status, set supervisor, clear trace
// RULE11: Reset and interrupts update priority mask
// RULE12: Interrupt vector from acknowledge in space F
// RULE13: Push status, PC and vector offset frame
// RULE14: Format zero means four-word frame
// RULE15: Load fetched vector into PC, resume
// RULE16: Reset aborts everything, saves nothing
// RULE17: Address error ranks above bus error
// RULE18: Traps in execution, group 3 before execution
// RULE19: Trace, breakpoint, interrupt after instruction boundary
// RULE20: Simultaneous exceptions each push frames in order
// RULE21: Reset first, clears all pending
// RULE22: Higher priority preempts lower exception entry; code preempts only on a bus fault, other causes wait for idle
// RULE23: Others keep off the low 64 entries
// RULE24: Reset sets mask 111, base zero
// RULE25: Fault during reset entry halts
// RULE26: Vector reads are single aligned long words
module cxv_core (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // Exception causes from the pipeline
  input wire addr_err_i,
  input wire bus_err_i,
  input wire trap_req_i,
  input wire [7:0] trap_vec_i,
  input wire ill_req_i,
  input wire [1:0] ill_kind_i,
  input wire trace_req_i,
  input wire breakpoint_instr_req_i,
  input wire [2:0] irq_level_i,
  input wire insn_boundary_i,
  input wire [31:0] cur_pc_i,
  // Software writes to control state
  input wire vbr_wr_i,
  input wire [31:0] vbr_wdata_i,
  input wire sr_wr_i,
  input wire [15:0] sr_wdata_i,
  // Bus master side
  output reg bus_req_o,
  output reg bus_we_o,
  output reg [31:0] bus_addr_o,
  output reg [31:0] bus_wdata_o,
  output reg [2:0] bus_fc_o,
  output reg [1:0] bus_size_o,
  input wire bus_ack_i,
  input wire bus_err_ack_i,
  input wire [31:0] bus_rdata_i,
  input wire iack_auto_i,
  // Core state outputs
  output reg [31:0] vector_table_base_o,
  output reg [15:0] status_word_o,
  output reg [31:0] pc_o,
  output reg [31:0] ssp_o,
  output reg pc_load_o,
  output reg in_exception_o,
  output reg halted_o
);
  // One-hot states
  localparam ST_IDLE = 9'h001;
  localparam ST_RST_SP = 9'h002;
  localparam ST_RST_PC = 9'h004;
  localparam ST_IACK = 9'h008;
  localparam ST_PUSH_PC_LO = 9'h010;
  localparam ST_PUSH_PC_HI = 9'h020;
  localparam ST_PUSH_SR = 9'h040;
  localparam ST_PUSH_FMT = 9'h080;
  localparam ST_FETCH = 9'h100;

  reg [8:0] state_q;
  reg [6:0] pend_q; // Latched pending causes
  reg [7:0] trap_vec_q;
  reg [1:0] ill_kind_q;
  reg [2:0] irq_lvl_q;
  reg [7:0] vec_q; // Vector being processed
  reg [15:0] sr_copy_q; // Internal status copy
  reg [31:0] pc_save_q;
  reg in_reset_q; // Reset entry in progress
  reg is_irq_q;
  // Synchronised level inputs from the pin side
  reg [2:0] irq_s1_q, irq_s2_q;
  reg berr_s1_q, berr_s2_q;
  wire [6:0] pick;
  wire any_pend;
  wire [6:0] pend_now;
  wire fault;
  // PC to save: a vector loaded last cycle is newer than the pipeline's PC
  wire [31:0] pc_now;

  // Vector fetch address: base plus number times four
  function [31:0] vec_addr;
    input [31:0] base;
    input [7:0] num;
    begin
      vec_addr = base + {22'h000000, num, 2'b00}; // [RULE4] [RULE1] [RULE26]
    end
  endfunction

  // Vector number for a picked cause
  function [7:0] vec_of;
    input [6:0] p;
    input [7:0] tv;
    input [1:0] ik;
    begin
      case (1'b1)
        p[`CXV_EX_ADDR]: vec_of = `CXV_VEC_ADDR_ERR; // [RULE7]
        p[`CXV_EX_BUS]: vec_of = `CXV_VEC_BUS_ERR;
        p[`CXV_EX_TRAP]: vec_of = tv; // [RULE9] pipeline gives 0x20+index or 5..7
        p[`CXV_EX_ILL]: begin
          case (ik)
            2'h0: vec_of = `CXV_VEC_ILLEGAL;
            2'h1: vec_of = `CXV_VEC_LINE_A;
            2'h2: vec_of = `CXV_VEC_LINE_F;
            default: vec_of = `CXV_VEC_PRIV;
          endcase
        end
        p[`CXV_EX_TRACE]: vec_of = `CXV_VEC_TRACE;
        p[`CXV_EX_BREAKPOINT_INSTR]: vec_of = `CXV_VEC_HW_BREAKPOINT_INSTR;
        default: vec_of = `CXV_VEC_UNINIT;
      endcase
    end
  endfunction

  // New causes join the latched ones; boundary-only causes wait
  assign pend_now = pend_q | {
    (irq_s2_q != 3'h0) && (irq_s2_q == `CXV_IPL_MAX || irq_s2_q > status_word_o[10:8]) && insn_boundary_i,
    breakpoint_instr_req_i && insn_boundary_i, trace_req_i && insn_boundary_i, // [RULE19]
    ill_req_i, trap_req_i, berr_s2_q, addr_err_i}; // [RULE18]
  assign fault = bus_err_ack_i;
  // Back-to-back entries stack the previous handler's address [RULE20]
  assign pc_now = pc_load_o ? pc_o : cur_pc_i;

  cxv_prio u_prio (
    .pend_i(pend_now),
    .pick_o(pick),
    .any_o(any_pend)
  );

  // Input synchronisers
  always @(posedge clk_sys_i) begin
    irq_s1_q <= irq_level_i;
    irq_s2_q <= irq_s1_q;
    berr_s1_q <= bus_err_i;
    berr_s2_q <= berr_s1_q;
  end

  // Main sequencer
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      // Reset aborts all, clears pending, no context saved
      state_q <= ST_RST_SP; // [RULE16] [RULE21]
      pend_q <= 7'h00;
      trap_vec_q <= 8'h00;
      ill_kind_q <= 2'h0;
      irq_lvl_q <= 3'h0;
      vec_q <= `CXV_VEC_RESET_SP;
      sr_copy_q <= 16'h0000;
      pc_save_q <= 32'h00000000;
      in_reset_q <= 1'b1;
      is_irq_q <= 1'b0;
      vector_table_base_o <= `CXV_VBR_RESET; // [RULE24]
      status_word_o <= `CXV_SR_RESET; // [RULE24] [RULE10] [RULE11]
      pc_o <= 32'h00000000;
      ssp_o <= 32'h00000000;
      pc_load_o <= 1'b0;
      in_exception_o <= 1'b1;
      halted_o <= 1'b0;
      bus_req_o <= 1'b0;
      bus_we_o <= 1'b0;
      bus_addr_o <= 32'h00000000;
      bus_wdata_o <= 32'h00000000;
      bus_fc_o <= `CXV_FC_SUP_PROG;
      bus_size_o <= 2'h0;
    end else begin
      pc_load_o <= 1'b0;
      // Causes stay latched until taken
      pend_q <= pend_now;
      if (trap_req_i) begin
        trap_vec_q <= trap_vec_i;
      end
      if (ill_req_i) begin
        ill_kind_q <= ill_kind_i;
      end
      // Software writes when not sequencing
      if (vbr_wr_i && state_q == ST_IDLE) begin
        vector_table_base_o <= vbr_wdata_i;
      end
      if (sr_wr_i && state_q == ST_IDLE) begin
        status_word_o <= sr_wdata_i;
      end
      if (halted_o) begin
        // Only reset leaves the halted state
        bus_req_o <= 1'b0;
      end else if (fault && in_reset_q) begin
        halted_o <= 1'b1; // [RULE25]
        bus_req_o <= 1'b0;
        state_q <= ST_IDLE;
      end else if (fault && state_q != ST_IDLE) begin
        // Bus error preempts the entry under way
        bus_req_o <= 1'b0;
        pend_q <= pend_now | 7'h02; // [RULE22]
        state_q <= ST_IDLE;
      end else begin
        case (state_q)
          ST_IDLE: begin
            in_exception_o <= any_pend;
            if (any_pend) begin
              // Copy status, then enter supervisor with trace off
              sr_copy_q <= status_word_o; // [RULE10]
              status_word_o[`CXV_SR_SUPER] <= 1'b1;
              status_word_o[`CXV_SR_TRACE_HIGH] <= 1'b0;
              status_word_o[`CXV_SR_TRACE_LOW] <= 1'b0;
              pc_save_q <= pc_now;
              pend_q <= pend_now & ~pick; // [RULE17] [RULE20]
              vec_q <= vec_of(pick, trap_vec_q, ill_kind_q); // [RULE5] [RULE7]
              if (pick[`CXV_EX_TRAP] && trap_req_i) begin
                vec_q <= trap_vec_i;
              end
              if (pick[`CXV_EX_ILL] && ill_req_i) begin
                vec_q <= vec_of(pick, trap_vec_q, ill_kind_i);
              end
              is_irq_q <= pick[`CXV_EX_IRQ];
              if (pick[`CXV_EX_IRQ]) begin
                // Acknowledge cycle in CPU space F for the number
                irq_lvl_q <= irq_s2_q;
                status_word_o[10:8] <= irq_s2_q; // [RULE11]
                bus_req_o <= 1'b1;
                bus_we_o <= 1'b0;
                bus_fc_o <= `CXV_FC_CPU_SPACE; // [RULE12]
                bus_addr_o <= {12'h000, `CXV_CPU_SPACE_IACK, 12'h000, irq_s2_q, 1'b1};
                bus_size_o <= 2'h1;
                state_q <= ST_IACK;
              end else begin
                state_q <= ST_PUSH_PC_LO;
                bus_req_o <= 1'b1;
                bus_we_o <= 1'b1;
                bus_fc_o <= `CXV_FC_SUP_DATA;
                bus_size_o <= 2'h1;
                // Top word of the frame is left for the format word
                bus_addr_o <= ssp_o - 32'h00000004;
                bus_wdata_o <= {16'h0000, pc_now[15:0]};
                ssp_o <= ssp_o - 32'h00000004;
              end
            end
          end
          ST_RST_SP: begin
            // Reset entry: first long word is the stack pointer
            if (!bus_req_o) begin
              bus_req_o <= 1'b1;
              bus_we_o <= 1'b0;
              bus_fc_o <= `CXV_FC_SUP_PROG; // [RULE6]
              bus_size_o <= 2'h0;
              bus_addr_o <= vec_addr(vector_table_base_o, `CXV_VEC_RESET_SP); // [RULE3]
            end else if (bus_ack_i) begin
              ssp_o <= bus_rdata_i; // [RULE26]
              bus_addr_o <= vec_addr(vector_table_base_o, `CXV_VEC_RESET_PC);
              state_q <= ST_RST_PC;
            end
          end
          ST_RST_PC: begin
            if (bus_ack_i) begin
              pc_o <= bus_rdata_i; // [RULE3]
              pc_load_o <= 1'b1;
              bus_req_o <= 1'b0;
              in_reset_q <= 1'b0;
              in_exception_o <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
          ST_IACK: begin
            if (bus_ack_i) begin
              // Device number, or autovector by level
              if (iack_auto_i) begin
                vec_q <= `CXV_VEC_AUTO_BASE + {5'h00, irq_lvl_q}; // [RULE8]
              end else begin
                vec_q <= bus_rdata_i[7:0]; // [RULE12] [RULE2]
              end
              bus_we_o <= 1'b1;
              bus_fc_o <= `CXV_FC_SUP_DATA;
              // Skip the format word slot at the frame top; it is written last
              bus_addr_o <= ssp_o - 32'h00000004;
              bus_wdata_o <= {16'h0000, pc_save_q[15:0]};
              ssp_o <= ssp_o - 32'h00000004;
              state_q <= ST_PUSH_PC_LO;
            end
          end
          ST_PUSH_PC_LO: begin
            if (bus_ack_i) begin
              bus_addr_o <= ssp_o - 32'h00000002;
              bus_wdata_o <= {16'h0000, pc_save_q[31:16]};
              ssp_o <= ssp_o - 32'h00000002;
              state_q <= ST_PUSH_PC_HI;
            end
          end
          ST_PUSH_PC_HI: begin
            if (bus_ack_i) begin
              bus_addr_o <= ssp_o - 32'h00000002;
              bus_wdata_o <= {16'h0000, sr_copy_q}; // [RULE13]
              ssp_o <= ssp_o - 32'h00000002;
              state_q <= ST_PUSH_SR;
            end
          end
          ST_PUSH_SR: begin
            if (bus_ack_i) begin
              // Format word sits above SR: format 0, vector offset
              bus_addr_o <= ssp_o + 32'h00000006;
              bus_wdata_o <= {16'h0000, `CXV_FRAME_FMT0, 2'b00, vec_q, 2'b00}; // [RULE14] [RULE13]
              state_q <= ST_PUSH_FMT;
            end
          end
          ST_PUSH_FMT: begin
            if (bus_ack_i) begin
              bus_we_o <= 1'b0;
              bus_size_o <= 2'h0;
              bus_fc_o <= `CXV_FC_SUP_DATA; // [RULE6]
              bus_addr_o <= vec_addr(vector_table_base_o, vec_q); // [RULE4]
              state_q <= ST_FETCH;
            end
          end
          ST_FETCH: begin
            if (bus_ack_i) begin
              pc_o <= bus_rdata_i; // [RULE15] [RULE26]
              pc_load_o <= 1'b1;
              bus_req_o <= 1'b0;
              state_q <= ST_IDLE; // Next pending taken from idle [RULE20]
            end
          end
          default: begin
            state_q <= ST_IDLE;
            bus_req_o <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: cxv_consts.vh
// Constants for the exception vectoring unit
`ifndef CXV_CONSTS_VH
`define CXV_CONSTS_VH
`define CXV_VEC_RESET_SP 8'h00
`define CXV_VEC_RESET_PC 8'h01
`define CXV_VEC_BUS_ERR 8'h02
`define CXV_VEC_ADDR_ERR 8'h03
`define CXV_VEC_ILLEGAL 8'h04
`define CXV_VEC_DIV_ZERO 8'h05
`define CXV_VEC_BOUNDS 8'h06
`define CXV_VEC_COND_TRAP 8'h07
`define CXV_VEC_PRIV 8'h08
`define CXV_VEC_TRACE 8'h09
`define CXV_VEC_LINE_A 8'h0A
`define CXV_VEC_LINE_F 8'h0B
`define CXV_VEC_HW_BREAKPOINT_INSTR 8'h0C
`define CXV_VEC_FORMAT 8'h0E
`define CXV_VEC_UNINIT 8'h0F
`define CXV_VEC_SPURIOUS 8'h18
`define CXV_VEC_AUTO_BASE 8'h18
`define CXV_VEC_TRAP_BASE 8'h20
`define CXV_VEC_USER_FIRST 8'h40
`define CXV_TABLE_BYTES 1024
`define CXV_TABLE_ENTRIES 256
`define CXV_FC_SUP_DATA 3'h5
`define CXV_FC_SUP_PROG 3'h6
`define CXV_FC_CPU_SPACE 3'h7
`define CXV_CPU_SPACE_IACK 4'hF
`define CXV_FRAME_FMT0 4'h0
`define CXV_SR_TRACE_HIGH 15
`define CXV_SR_TRACE_LOW 14
`define CXV_SR_SUPER 13
`define CXV_SR_MASK_LSB 8
`define CXV_IPL_MAX 3'h7
`define CXV_VBR_RESET 32'h00000000
`define CXV_SR_RESET 16'h2700
// Exception cause bit positions in the pending vector
`define CXV_EX_ADDR 0
`define CXV_EX_BUS 1
`define CXV_EX_TRAP 2
`define CXV_EX_ILL 3
`define CXV_EX_TRACE 4
`define CXV_EX_BREAKPOINT_INSTR 5
`define CXV_EX_IRQ 6
`define CXV_EX_N 7
`endif

// file: cxv_prio.v
// Priority picker for pending exceptions
`timescale 1ns/1ps
`default_nettype none
module cxv_prio (
  // Pending causes, bit 0 highest priority
  input wire [6:0] pend_i,
  // One-hot winner and any-pending flag
  output reg [6:0] pick_o,
  output wire any_o
);
  integer k;
  reg found;
  assign any_o = |pend_i;
  // Lowest index wins; cause order fixes priority
  always @* begin
    pick_o = 7'h00;
    found = 1'b0;
    for (k = 0; k < 7; k = k + 1) begin
      if (pend_i[k] && !found) begin
        pick_o[k] = 1'b1;
        found = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: cxv_chk.sv
// Port checker for the exception vectoring core
`timescale 1ns/1ps
`default_nettype none
`include "cxv_consts.vh"
module cxv_chk (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Watched ports
  input wire logic bus_req_o,
  input wire logic bus_we_o,
  input wire logic [31:0] bus_addr_o,
  input wire logic [2:0] bus_fc_o,
  input wire logic [1:0] bus_size_o,
  input wire logic bus_ack_i,
  input wire logic bus_err_ack_i,
  input wire logic [31:0] bus_rdata_i,
  input wire logic [31:0] vector_table_base_o,
  input wire logic [15:0] status_word_o,
  input wire logic [31:0] pc_o,
  input wire logic pc_load_o,
  input wire logic halted_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Table read, acknowledge cycles excluded
  wire logic rd = bus_req_o && !bus_we_o && bus_fc_o != `CXV_FC_CPU_SPACE;
  // Reset fetch, stack pointer step
  sequence s_sp;
    bus_req_o && bus_fc_o == `CXV_FC_SUP_PROG && bus_addr_o == vector_table_base_o;
  endsequence
  // Reset fetch, program counter step
  sequence s_pc;
    bus_req_o && bus_fc_o == `CXV_FC_SUP_PROG && bus_addr_o == vector_table_base_o + 32'h4;
  endsequence
  a_reset_vals: assert property (
    $fell(reset_i) |-> status_word_o == `CXV_SR_RESET && vector_table_base_o == 32'h0 ##1 s_sp)
    else $error("reset state or first fetch wrong");
  a_sp_then_pc: assert property (s_sp ##0 bus_ack_i |=> s_pc)
    else $error("second reset word not fetched next");
  a_read_aligned: assert property (
    rd |-> bus_addr_o[1:0] == 2'b00 && bus_size_o == 2'b00 && bus_addr_o - vector_table_base_o < 32'd1024)
    else $error("table read misplaced or not long");
  a_read_space: assert property (
    rd |-> (bus_fc_o == `CXV_FC_SUP_PROG) == (bus_addr_o - vector_table_base_o < 32'h8))
    else $error("table read in wrong space");
  a_iack_addr: assert property (
    bus_req_o && bus_fc_o == `CXV_FC_CPU_SPACE |-> !bus_we_o && bus_addr_o[31:4] == 28'h000F000 && bus_addr_o[0])
    else $error("acknowledge cycle malformed");
  a_sup_in_frame: assert property (
    bus_req_o && bus_we_o |-> status_word_o[`CXV_SR_SUPER] && status_word_o[15:14] == 2'b00)
    else $error("frame written outside supervisor state");
  a_pc_from_read: assert property (
    pc_load_o |-> $past(bus_ack_i) && pc_o == $past(bus_rdata_i))
    else $error("program counter not the fetched word");
  a_req_stands: assert property (
    bus_req_o && !bus_ack_i && !bus_err_ack_i |=> bus_req_o && $stable(bus_addr_o) && $stable(bus_we_o))
    else $error("request changed before answer");
  a_halt_holds: assert property (halted_o |=> halted_o && !bus_req_o)
    else $error("halted core left halt or used the bus");
endmodule
bind cxv_core cxv_chk cxv_chk_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .bus_req_o(bus_req_o),
  .bus_we_o(bus_we_o), .bus_addr_o(bus_addr_o), .bus_fc_o(bus_fc_o), .bus_size_o(bus_size_o),
  .bus_ack_i(bus_ack_i), .bus_err_ack_i(bus_err_ack_i), .bus_rdata_i(bus_rdata_i),
  .vector_table_base_o(vector_table_base_o), .status_word_o(status_word_o), .pc_o(pc_o),
  .pc_load_o(pc_load_o), .halted_o(halted_o));
`default_nettype wire

// file: cxv_mem.sv
// Vector table memory and interrupting peripheral model
`timescale 1ns/1ps
`default_nettype none
`include "cxv_consts.vh"
module cxv_mem (
  // Clock
  input wire logic clk_sys_i,
  // Request from the core
  input wire logic req_i,
  input wire logic [31:0] addr_i,
  input wire logic [2:0] fc_i,
  // Bench knobs: wait states, fault, vector, autovector
  input wire logic [1:0] lat_i,
  input wire logic err_i,
  input wire logic [7:0] vec_i,
  input wire logic auto_i,
  // Answers
  output logic ack_o,
  output logic err_ack_o,
  output logic [31:0] rdata_o,
  output logic auto_o
);
  logic [1:0] wait_q; // Wait states spent
  initial begin
    {ack_o, err_ack_o, auto_o, wait_q} = '0;
    rdata_o = 32'h0;
  end
  // One answer per request, then a gap; never touches the table itself
  always @(posedge clk_sys_i) begin
    {ack_o, err_ack_o, auto_o} <= 3'b000;
    rdata_o <= ~rdata_o; // Released data toggles so stale words are never reused
    if (req_i && !ack_o && !err_ack_o) begin
      wait_q <= wait_q + 2'h1;
      if (wait_q >= lat_i) begin
        wait_q <= 2'h0;
        ack_o <= !err_i;
        err_ack_o <= err_i;
        auto_o <= auto_i && fc_i == `CXV_FC_CPU_SPACE;
        // Peripheral returns its number on acknowledge
        rdata_o <= fc_i == `CXV_FC_CPU_SPACE ? {24'h0, vec_i} : addr_i ^ 32'h5A5A0000;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the exception vectoring core
`timescale 1ns/1ps
`default_nettype none
`include "cxv_consts.vh"
module tb_top;
  // Design inputs
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic addr_err_i, bus_err_i, trap_req_i, ill_req_i, trace_req_i, breakpoint_instr_req_i, insn_boundary_i, vbr_wr_i, sr_wr_i;
  logic [7:0] trap_vec_i;
  logic [1:0] ill_kind_i;
  logic [2:0] irq_level_i;
  logic [31:0] cur_pc_i, vbr_wdata_i;
  logic [15:0] sr_wdata_i;
  // Design outputs and partner answers
  wire bus_req_o, bus_we_o, pc_load_o, in_exception_o, halted_o, bus_ack_i, bus_err_ack_i, iack_auto_i;
  wire [31:0] bus_addr_o, bus_wdata_o, bus_rdata_i, vector_table_base_o, pc_o, ssp_o;
  wire [15:0] status_word_o;
  wire [2:0] bus_fc_o;
  wire [1:0] bus_size_o;
  // Partner knobs and bench model
  logic [1:0] lat;
  logic err, auto;
  logic [7:0] vec;
  logic [31:0] vb, pc_m, sp_m;
  logic [15:0] sr_m;
  logic [15:0] wq[$];
  logic [31:0] rq[$];
  logic [31:0] aq[$];
  int n_fail, total_checks, v, i;
  int vt[9] = '{5, 6, 7, 4, 10, 11, 8, 9, 12};
  always #4 clk_sys_i = ~clk_sys_i;
  cxv_core cxv_core_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_err_i(addr_err_i),
    .bus_err_i(bus_err_i), .trap_req_i(trap_req_i), .trap_vec_i(trap_vec_i), .ill_req_i(ill_req_i),
    .ill_kind_i(ill_kind_i), .trace_req_i(trace_req_i), .breakpoint_instr_req_i(breakpoint_instr_req_i), .irq_level_i(irq_level_i),
    .insn_boundary_i(insn_boundary_i), .cur_pc_i(cur_pc_i), .vbr_wr_i(vbr_wr_i), .vbr_wdata_i(vbr_wdata_i),
    .sr_wr_i(sr_wr_i), .sr_wdata_i(sr_wdata_i), .bus_req_o(bus_req_o), .bus_we_o(bus_we_o),
    .bus_addr_o(bus_addr_o), .bus_wdata_o(bus_wdata_o), .bus_fc_o(bus_fc_o), .bus_size_o(bus_size_o),
    .bus_ack_i(bus_ack_i), .bus_err_ack_i(bus_err_ack_i), .bus_rdata_i(bus_rdata_i), .iack_auto_i(iack_auto_i),
    .vector_table_base_o(vector_table_base_o), .status_word_o(status_word_o), .pc_o(pc_o), .ssp_o(ssp_o),
    .pc_load_o(pc_load_o), .in_exception_o(in_exception_o), .halted_o(halted_o));
  cxv_mem cxv_mem_inst (.clk_sys_i(clk_sys_i), .req_i(bus_req_o), .addr_i(bus_addr_o), .fc_i(bus_fc_o),
    .lat_i(lat), .err_i(err), .vec_i(vec), .auto_i(auto), .ack_o(bus_ack_i), .err_ack_o(bus_err_ack_i),
    .rdata_o(bus_rdata_i), .auto_o(iack_auto_i));
  // Log stack writes and table reads; drop a fault or a request once served
  always @(posedge clk_sys_i) begin
    if (bus_err_ack_i) err <= 1'b0;
    if (bus_req_o && bus_ack_i && bus_we_o) wq.push_back(bus_wdata_o[15:0]);
    if (bus_req_o && bus_ack_i && bus_we_o) aq.push_back(bus_addr_o);
    if (bus_req_o && bus_ack_i && !bus_we_o && bus_fc_o != `CXV_FC_CPU_SPACE) rq.push_back(bus_addr_o);
    if (bus_req_o && bus_ack_i && bus_fc_o == `CXV_FC_CPU_SPACE) irq_level_i <= 3'h0;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic hang;
    n_fail++;
    close_out();
  endtask
  // Bounded wait for the vector load
  task automatic wait_pl;
    int k;
    for (k = 0; k < 300 && pc_load_o !== 1'b1; k++) @(negedge clk_sys_i);
    if (k == 300) hang();
  endtask
  // Bounded wait until no entry runs, then forget the traffic
  task automatic idle;
    int k;
    for (k = 0; k < 400 && in_exception_o !== 1'b0; k++) @(negedge clk_sys_i);
    if (k == 400) hang();
    wq.delete();
    rq.delete();
    aq.delete();
  endtask
  task automatic boot;
    wait_pl();
    chk("sp_addr", 0, rq[0]);
    chk("pc_addr", 4, rq[1]);
    chk("ssp", 32'h5A5A0000, ssp_o);
    chk("pc", 32'h5A5A0004, pc_o);
    chk("sr", `CXV_SR_RESET, status_word_o);
    chk("halt", 0, halted_o);
    @(negedge clk_sys_i);
    idle();
  endtask
  // Fresh base, status and saved PC while idle
  task automatic setup(input logic [15:0] s);
    @(posedge clk_sys_i);
    vb = $urandom & 32'hFFFFFFFC;
    pc_m = $urandom & 32'hFFFFFFFE;
    {vbr_wr_i, sr_wr_i} <= 2'b11;
    vbr_wdata_i <= vb;
    sr_wdata_i <= s;
    cur_pc_i <= pc_m;
    lat <= $urandom % 4;
    @(posedge clk_sys_i);
    {vbr_wr_i, sr_wr_i} <= 2'b00;
    sr_m = s;
    @(negedge clk_sys_i);
    chk("base", vb, vector_table_base_o);
    chk("sr_wr", s, status_word_o);
    sp_m = ssp_o;
  endtask
  // One entry: frame, vector address, new PC and status; lvl below 0 keeps the mask
  task automatic entry(input int v, input int lvl);
    logic [31:0] a;
    wait_pl();
    a = vb + v * 4;
    chk("vaddr", a, rq[$]);
    chk("npc", a ^ 32'h5A5A0000, pc_o);
    chk("pclo", pc_m[15:0], wq[0]);
    chk("pchi", pc_m[31:16], wq[1]);
    chk("srcp", sr_m, wq[2]);
    chk("fmt", v * 4, wq[3]);
    chk("frsp", aq[2], ssp_o);
    chk("frtop", 1, aq[3] < sp_m);
    chk("inexc", 1, in_exception_o);
    sp_m = aq[2];
    sr_m = {3'b001, sr_m[12:11], lvl < 0 ? sr_m[10:8] : lvl[2:0], sr_m[7:0]};
    chk("srn", sr_m, status_word_o);
    pc_m = a ^ 32'h5A5A0000;
    wq.delete();
    rq.delete();
    aq.delete();
    @(negedge clk_sys_i);
  endtask
  // Raise one internal cause: traps, fixed traps, group 3 kinds, trace, breakpoint
  task automatic fire(input int c);
    @(posedge clk_sys_i);
    trap_req_i <= c < 19;
    trap_vec_i <= c < 16 ? 8'h20 + c[7:0] : c[7:0] - 8'd11;
    ill_req_i <= c >= 19 && c <= 22;
    ill_kind_i <= c[1:0] + 2'd1;
    trace_req_i <= c == 23;
    breakpoint_instr_req_i <= c == 24;
    @(posedge clk_sys_i);
    {trap_req_i, ill_req_i, trace_req_i, breakpoint_instr_req_i} <= 4'h0;
  endtask
  initial begin
    {addr_err_i, bus_err_i, trap_req_i, ill_req_i, trace_req_i, breakpoint_instr_req_i, vbr_wr_i, sr_wr_i, err, auto} = '0;
    {trap_vec_i, ill_kind_i, irq_level_i, cur_pc_i, vbr_wdata_i, sr_wdata_i, vec, lat} = '0;
    insn_boundary_i = 1'b1;
    {n_fail, total_checks} = '0;
    v = $urandom(32'h170703f8);
    repeat (4) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    boot();
    for (i = 0; i < 25; i++) begin
      setup(16'hC000);
      fire(i);
      entry(i < 16 ? 32 + i : vt[i - 16], -1);
      idle();
    end
    // Address error beside a trap, then beside a bus error
    for (i = 0; i < 2; i++) begin
      setup(16'hC000);
      @(posedge clk_sys_i);
      {addr_err_i, bus_err_i, trap_req_i} <= {1'b1, i == 1, i == 0};
      trap_vec_i <= 8'h2F;
      @(posedge clk_sys_i);
      {addr_err_i, trap_req_i} <= 2'b00;
      repeat (2) @(posedge clk_sys_i);
      bus_err_i <= 1'b0;
      entry(3, -1);
      entry(i == 0 ? 47 : 2, -1);
      idle();
    end
    // Interrupts at every level, trace beside level 2, device number at level 4
    for (i = 1; i < 8; i++) begin
      setup(16'hC000);
      v = i == 4 ? 64 + $urandom % 192 : 24 + i;
      @(posedge clk_sys_i);
      vec <= v[7:0];
      auto <= i != 4;
      irq_level_i <= i[2:0];
      trace_req_i <= i == 2;
      @(posedge clk_sys_i);
      trace_req_i <= 1'b0;
      if (i == 2) entry(9, -1);
      entry(v, i);
      idle();
    end
    // Bus fault in trace entry is taken in place of the trace
    setup(16'hC000);
    @(posedge clk_sys_i);
    {err, trace_req_i} <= 2'b11;
    @(posedge clk_sys_i);
    trace_req_i <= 1'b0;
    sr_m = 16'h2000;
    entry(2, -1);
    idle();
    // Fault in reset entry halts; a second reset clears a cause raised meanwhile
    for (i = 0; i < 2; i++) begin
      @(posedge clk_sys_i);
      {err, addr_err_i} <= {i == 0, i == 1};
      @(posedge clk_sys_i);
      reset_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      {reset_i, addr_err_i} <= 2'b00;
      if (i == 0) begin
        repeat (12) @(negedge clk_sys_i);
        chk("halted", 1, halted_o);
        chk("halt_bus", 0, bus_req_o);
      end
    end
    rq.delete();
    boot();
    repeat (20) @(negedge clk_sys_i);
    chk("no_pend", 0, rq.size() + wq.size());
    close_out();
  end
endmodule
`default_nettype wire
